// file: level_b_pkg.sv
// constants and register map for the input b level indicator
package level_b_pkg;
   localparam int          ADDR_W        = 3;
   localparam int          DATA_W        = 20;
   localparam int          THR_W         = 10;
   localparam int          DWELL_W       = 20;
   localparam int          CTRL_W        = 5;
   localparam int          LAT_W         = 3;
   localparam int          LAT_MAX       = 7;
   localparam int          CH_N          = 2;
   // channel addresses of the b group
   localparam logic [2:0]  ADDR_LOWER    = 3'h4;
   localparam logic [2:0]  ADDR_UPPER    = 3'h5;
   localparam logic [2:0]  ADDR_DWELL    = 3'h6;
   localparam logic [2:0]  ADDR_CTRL     = 3'h7;
   // control field layout
   localparam int          CTRL_POL_BIT  = 4;
   localparam int          CTRL_IL_BIT   = 3;
   localparam int          CTRL_LAT_MSB  = 2;
   localparam int          CTRL_LAT_LSB  = 0;
   // reset values
   localparam logic [THR_W-1:0]   LOWER_RST  = 10'h000;
   localparam logic [THR_W-1:0]   UPPER_RST  = 10'h000;
   localparam logic [DWELL_W-1:0] DWELL_RST  = 20'h00000;
   localparam logic [CTRL_W-1:0]  CTRL_RST   = 5'h00;
   localparam logic               PRIM_RST   = 1'b0;
   localparam logic               SEC_RST    = 1'b1;
   localparam logic [DWELL_W-1:0] DWELL_ONE  = 20'h00001;
endpackage : level_b_pkg

// file: level_delay.sv
// selectable delay line for the raw indicator flags
`timescale 1ns/1ps
module level_delay
   import level_b_pkg::*;
#(
   parameter int W     = CH_N,
   parameter int DEPTH = LAT_MAX
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [W-1:0]     d_i,
   input  wire logic [LAT_W-1:0] sel_i,
   output logic      [W-1:0]     q_o
);
   logic [W-1:0] stage_reg [DEPTH];

   // one flop per tap; tap k holds the flags k+1 cycles old
   genvar k;
   generate
      for (k = 0; k < DEPTH; k++)
      begin : g_tap
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               stage_reg[k] <= '0;
            else if (k == 0)
               stage_reg[k] <= d_i;
            else
               stage_reg[k] <= stage_reg[(k == 0) ? 0 : k - 1];
         end
      end
   endgenerate

   // changing the tap mid-run may drop or repeat a few cycles of flag
   always_comb
   begin
      if (sel_i == '0)
         q_o = d_i;
      else
         q_o = stage_reg[sel_i - LAT_W'(1)];
   end
endmodule : level_delay

// file: input_level_indicator_b.sv
// level detector for wideband input b with dwell release and latency
`timescale 1ns/1ps
module input_level_indicator_b
   import level_b_pkg::*;
#(
   parameter int SAMPLE_W = 14
)
(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic [SAMPLE_W-1:0] sample_i,
   input  wire logic                input_b_channel_select_pin_i,
   input  wire logic                reg_wr_i,
   input  wire logic [ADDR_W-1:0]   reg_addr_i,
   input  wire logic [DATA_W-1:0]   reg_wdata_i,
   output logic      [DATA_W-1:0]   reg_rdata_o,
   output logic                     level_flag_b_primary_o,
   output logic                     level_flag_b_secondary_o
);
   logic [THR_W-1:0]    lower_reg;
   logic [THR_W-1:0]    upper_reg;
   logic [DWELL_W-1:0]  dwell_reg;
   logic [CTRL_W-1:0]   ctrl_reg;
   logic [DATA_W-1:0]   rdata_next;
   logic                pin_meta_reg;
   logic                pin_sync_reg;
   logic [SAMPLE_W-1:0] sample_d1_reg;
   logic [SAMPLE_W-1:0] sample_d2_reg;
   logic [THR_W-1:0]    sample_top;
   logic                upper_met;
   logic                lower_met;
   logic                enabled;
   logic                pol;
   logic                interleave;
   logic [LAT_W-1:0]    latency;
   logic [CH_N-1:0]     level_flag;
   logic [DWELL_W-1:0]  cnt_reg [CH_N];
   logic [CH_N-1:0]     dly_flag;

   // register writes from the control port
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lower_reg <= LOWER_RST;
         upper_reg <= UPPER_RST;
         dwell_reg <= DWELL_RST;
         ctrl_reg  <= CTRL_RST;
      end
      else if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            ADDR_LOWER: lower_reg <= reg_wdata_i[THR_W-1:0];
            ADDR_UPPER: upper_reg <= reg_wdata_i[THR_W-1:0];
            ADDR_DWELL: dwell_reg <= reg_wdata_i[DWELL_W-1:0];
            ADDR_CTRL:  ctrl_reg  <= reg_wdata_i[CTRL_W-1:0];
            default:    ;
         endcase
      end
   end

   // read-back mux; other channel addresses read as zero
   always_comb
   begin
      rdata_next = '0;
      unique case (reg_addr_i)
         ADDR_LOWER: rdata_next = {{(DATA_W-THR_W){1'b0}}, lower_reg};
         ADDR_UPPER: rdata_next = {{(DATA_W-THR_W){1'b0}}, upper_reg};
         ADDR_DWELL: rdata_next = dwell_reg;
         ADDR_CTRL:  rdata_next = {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
         default:    rdata_next = '0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         reg_rdata_o <= '0;
      else
         reg_rdata_o <= rdata_next;
   end

   // select pin is asynchronous; samples get the same two stages to stay aligned
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_meta_reg  <= 1'b0;
         pin_sync_reg  <= 1'b0;
         sample_d1_reg <= '0;
         sample_d2_reg <= '0;
      end
      else
      begin
         pin_meta_reg  <= input_b_channel_select_pin_i;
         pin_sync_reg  <= pin_meta_reg;
         sample_d1_reg <= sample_i;
         sample_d2_reg <= sample_d1_reg;
      end
   end

   // threshold compares on the top mantissa bits
   assign sample_top = sample_d2_reg[SAMPLE_W-1 -: THR_W];
   assign upper_met  = (sample_top >= upper_reg);
   assign lower_met  = (sample_top <= lower_reg);
   assign enabled    = (dwell_reg != '0);
   assign pol        = ctrl_reg[CTRL_POL_BIT];
   assign interleave = ctrl_reg[CTRL_IL_BIT];
   assign latency    = ctrl_reg[CTRL_LAT_MSB:CTRL_LAT_LSB];

   // one detector per time slot; slot 1 only lives in interleaved mode
   genvar ch;
   generate
      for (ch = 0; ch < CH_N; ch++)
      begin : g_det
         localparam logic CH_ID = 1'(ch);
         logic slot_sel;
         assign slot_sel = interleave ? (pin_sync_reg == CH_ID) : (CH_ID == 1'b0);

         always_ff @(posedge clk_i)
         begin
            if (rst_i || !enabled || (!interleave && CH_ID))
            begin
               level_flag[ch] <= 1'b0;
               cnt_reg[ch]    <= '0;
            end
            else if (slot_sel)
            begin
               if (upper_met)
               begin
                  level_flag[ch] <= 1'b1;
                  cnt_reg[ch]    <= dwell_reg;
               end
               else if (level_flag[ch])
               begin
                  if (!lower_met)
                     cnt_reg[ch] <= dwell_reg;
                  else if (cnt_reg[ch] <= DWELL_ONE)
                     level_flag[ch] <= 1'b0;
                  else
                     cnt_reg[ch] <= cnt_reg[ch] - DWELL_ONE;
               end
            end
         end
      end
   endgenerate

   // latency delay ahead of the output flops
   level_delay #(
      .W     (CH_N),
      .DEPTH (LAT_MAX)
   ) u_delay (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (level_flag),
      .sel_i (latency),
      .q_o   (dly_flag)
   );

   // polarity applied last so both modes share it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         level_flag_b_primary_o   <= PRIM_RST;
         level_flag_b_secondary_o <= SEC_RST;
      end
      else
      begin
         level_flag_b_primary_o <= dly_flag[0] ^ pol;
         if (interleave)
            level_flag_b_secondary_o <= dly_flag[1] ^ pol;
         else
            level_flag_b_secondary_o <= ~(dly_flag[0] ^ pol);
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence upper_hit_s;
      enabled && !interleave && upper_met;
   endsequence

   sequence below_last_s;
      enabled && !interleave && level_flag[0] && !upper_met && lower_met
         && (cnt_reg[0] == DWELL_ONE);
   endsequence

   sequence between_s;
      enabled && !interleave && level_flag[0] && !upper_met && !lower_met;
   endsequence

   upper_sets_a: assert property (upper_hit_s |=> level_flag[0])
      else $error("upper threshold did not raise the flag");
   expire_clears_a: assert property (below_last_s ##1 (enabled && !interleave)
      |-> !level_flag[0])
      else $error("flag not released at dwell expiry");
   reload_dwell_a: assert property (between_s ##1 (dwell_reg == $past(dwell_reg))
      |-> cnt_reg[0] == dwell_reg)
      else $error("dwell counter not reloaded above lower threshold");
   dwell_count_a: assert property (enabled && !interleave && level_flag[0] && !upper_met
      && lower_met && (cnt_reg[0] > DWELL_ONE) ##1 (enabled && !interleave)
      |-> cnt_reg[0] == $past(cnt_reg[0]) - DWELL_ONE)
      else $error("dwell counter did not step down");
   zero_dwell_a: assert property (!enabled |=> level_flag == '0)
      else $error("flag active with zero dwell");
   single_compl_a: assert property ($past(!interleave)
      |-> level_flag_b_secondary_o != level_flag_b_primary_o)
      else $error("secondary is not the complement in single mode");
   slot_route_a: assert property (enabled && interleave && upper_met && pin_sync_reg
      ##1 (enabled && interleave) |-> level_flag[1])
      else $error("high slot did not reach secondary flag");
   polarity_a: assert property ($past(interleave) |->
      (level_flag_b_primary_o == ($past(dly_flag[0]) ^ $past(pol)))
      && (level_flag_b_secondary_o == ($past(dly_flag[1]) ^ $past(pol))))
      else $error("polarity not applied to both outputs");
   latency_two_a: assert property ((latency == LAT_W'(2)) ##1 (latency == LAT_W'(2))
      ##1 (latency == LAT_W'(2)) |-> dly_flag == $past(level_flag, 2))
      else $error("latency delay does not match setting");
endmodule : input_level_indicator_b

// file: gain_stage_model.sv
// partner model: attenuator and converter feeding input b
`timescale 1ns/1ps
module gain_stage_model
(
   input  wire logic [9:0]  level_i,
   input  wire logic [3:0]  noise_i,
   output logic      [13:0] sample_o
);
   // commanded magnitude on top, noise below so the low bits never matter
   assign sample_o = {level_i, noise_i};
endmodule : gain_stage_model

// file: input_level_indicator_b_bench.sv
// queue-checked bench for the input b level indicator
`timescale 1ns/1ps
module input_level_indicator_b_bench;
   import level_b_pkg::*;
   typedef struct {int due; bit sel; logic [19:0] exp;} note_t;
   note_t       q[$];
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        pin   = 1'b0;
   logic        wr    = 1'b0;
   logic [2:0]  addr  = 3'h0;
   logic [19:0] wdata = 20'h00000;
   logic [9:0]  lvl   = 10'h200;
   logic [3:0]  noise = 4'h0;
   logic [31:0] seed  = 32'h11df6b4d;
   logic [13:0] sample;
   logic [19:0] rdata;
   logic        prim;
   logic        sec;
   int          mismatches = 0;
   int          cmp_count  = 0;
   int          cyc        = 0;
   int          d0;
   int          d3;

   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;

   gain_stage_model partner (.level_i(lvl), .noise_i(noise), .sample_o(sample));
   input_level_indicator_b uut (.clk_i(clk_i), .rst_i(rst_i), .sample_i(sample),
      .input_b_channel_select_pin_i(pin), .reg_wr_i(wr), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .level_flag_b_primary_o(prim),
      .level_flag_b_secondary_o(sec));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // inputs move 1 ns after the edge; noise is fresh every cycle
   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         #1;
         seed = xs(seed);
         noise = seed[3:0];
      end
   endtask : step

   task automatic note(input bit sel, input logic [19:0] exp);
      q.push_back('{cyc, sel, exp});
   endtask : note

   task automatic flags(input logic [1:0] e);
      note(1'b0, {18'h00000, e});
   endtask : flags

   // one idle cycle after each strobe so wr is never set twice at once
   task automatic wr_reg(input logic [2:0] a, input logic [19:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      step(1);
   endtask : wr_reg

   task automatic rd(input logic [2:0] a, input logic [19:0] e);
      addr = a;
      step(1);
      note(1'b1, e);
   endtask : rd

   // level for n cycles, then between thresholds long enough to settle
   task automatic pulse(input logic [9:0] v, input int n);
      lvl = v;
      step(n);
      lvl = 10'h200;
      step(16);
   endtask : pulse

   task automatic measure(output int d);
      int k;
      lvl = 10'h300;
      step(1);
      lvl = 10'h200;
      k = 1;
      while (prim !== 1'b1 && k < 30)
      begin
         step(1);
         k++;
      end
      d = k;
   endtask : measure

   // results are taken oldest first once their cycle has come
   always @(negedge clk_i)
      while (q.size() > 0 && q[0].due <= cyc)
      begin
         if (q[0].sel)
            check(rdata, q[0].exp);
         else
            check({18'h00000, prim, sec}, q[0].exp);
         void'(q.pop_front());
      end

   initial
   begin
      step(16);
      rst_i = 1'b0;
      flags(2'b01);
      rd(ADDR_CTRL, 20'h00000);
      wr_reg(ADDR_LOWER, 20'h00100);
      wr_reg(ADDR_UPPER, 20'hfff00);
      wr_reg(ADDR_DWELL, 20'h00002);
      wr_reg(3'h2, 20'h12345);
      rd(ADDR_LOWER, 20'h00100);
      rd(ADDR_UPPER, 20'h00300);
      rd(ADDR_DWELL, 20'h00002);
      rd(3'h2, 20'h00000);
      $display("registers done");
      pulse(10'h2ff, 3);
      flags(2'b01);
      pulse(10'h300, 1);
      flags(2'b10);
      pulse(10'h101, 5);
      flags(2'b10);
      pulse(10'h100, 1);
      flags(2'b10);
      pulse(10'h100, 2);
      flags(2'b01);
      $display("dwell done");
      wr_reg(ADDR_DWELL, 20'h00001);
      measure(d0);
      pulse(10'h000, 1);
      wr_reg(ADDR_CTRL, 20'h00002);
      rd(ADDR_CTRL, 20'h00002);
      measure(d3);
      pulse(10'h000, 1);
      check(20'(d3 - d0), 20'h00002);
      $display("latency done");
      wr_reg(ADDR_CTRL, 20'h00010);
      flags(2'b10);
      pulse(10'h300, 1);
      flags(2'b01);
      pulse(10'h000, 1);
      wr_reg(ADDR_DWELL, 20'h00000);
      pulse(10'h300, 3);
      flags(2'b10);
      wr_reg(ADDR_DWELL, 20'h00001);
      $display("polarity done");
      wr_reg(ADDR_CTRL, 20'h00008);
      pulse(10'h300, 1);
      flags(2'b10);
      pin = 1'b1;
      pulse(10'h300, 1);
      flags(2'b11);
      pulse(10'h000, 1);
      flags(2'b10);
      wr_reg(ADDR_CTRL, 20'h00018);
      flags(2'b01);
      pin = 1'b0;
      step(4);
      pulse(10'h000, 1);
      flags(2'b11);
      step(2);
      $display("interleave done");
      print_verdict();
   end

   // the tests need well under a thousand cycles
   initial
   begin
      #(50 * 3000);
      mismatches++;
      print_verdict();
   end
endmodule : input_level_indicator_b_bench
